// ===== bpm_pkg.sv
/*
 Constants for the bidirectional port and pin multiplexer:
 register indices, masks, reset values and field positions.
 Assumes a byte-wide register port with a 4-bit address.
*/
`default_nettype none
package bpm_pkg;
   localparam int W = 8;
   // Register indices on the address port.
   localparam logic [3:0] A_C_PORT = 4'h0;
   localparam logic [3:0] A_C_LAT  = 4'h1;
   localparam logic [3:0] A_C_DIR  = 4'h2;
   localparam logic [3:0] A_C_ANS  = 4'h3;
   localparam logic [3:0] A_D_PORT = 4'h4;
   localparam logic [3:0] A_D_LAT  = 4'h5;
   localparam logic [3:0] A_D_DIR  = 4'h6;
   localparam logic [3:0] A_D_ANS  = 4'h7;
   localparam logic [3:0] A_SLEW   = 4'h8;
   localparam logic [3:0] A_MAP    = 4'h9;
   // Implemented-bit masks.
   localparam logic [7:0] C_ANS_MASK = 8'hfc;
   localparam logic [7:0] SLEW_MASK  = 8'h1f;
   localparam logic [7:0] MAP_MASK   = 8'h35;
   // Reset values.
   localparam logic [7:0] RST_LAT  = 8'h00;
   localparam logic [7:0] RST_DIR  = 8'hff;
   localparam logic [7:0] RST_C_ANS = 8'hfc;
   localparam logic [7:0] RST_D_ANS = 8'hff;
   localparam logic [7:0] RST_SLEW = 8'h1f;
   localparam logic [7:0] RST_MAP  = 8'h35;
   localparam logic [7:0] ZERO8    = 8'h00;
   // Field positions in the pin mapping register.
   localparam int MAP_PWM2B = 5;
   localparam int MAP_T3CK  = 4;
   localparam int MAP_CAPTURE_COMPARE_3  = 2;
   localparam int MAP_CAPTURE_COMPARE_2  = 0;
   // Pin positions.
   localparam int P5 = 5;
   localparam int P6 = 6;
   localparam int P7 = 7;
   localparam int D_PWM2B = 2;
endpackage : bpm_pkg
`default_nettype wire

// ===== bpm_port_mux.sv
/*
 Two 8-bit bidirectional ports (third and fourth) with direction,
 output latch, analog select, slew control and peripheral pin mux.
 Assumes a byte-wide register port with one-cycle strobes and
 pad signals synchronous to sys_clk; the pad resolves the wire.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module bpm_port_mux
   import bpm_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [7:0]  third_port_in,
   output logic      [7:0]  third_port_out,
   output logic      [7:0]  third_port_oe,
   input  wire logic [7:0]  fourth_port_in,
   output logic      [7:0]  fourth_port_out,
   output logic      [7:0]  fourth_port_oe,
   output logic      [7:0]  slew_rate_control,
   input  wire logic        spi1_data_out,
   input  wire logic        spi1_out_en,
   input  wire logic        capture_compare_3,
   input  wire logic        capture_compare_3_out_en,
   input  wire logic        pwm3_output_a,
   input  wire logic        pwm3a_en,
   input  wire logic        pwm3_output_b,
   input  wire logic        pwm3b_en,
   input  wire logic        uart1_transmit,
   input  wire logic        uart1_tx_en,
   input  wire logic        uart1_sync_clock,
   input  wire logic        uart1_sck_en,
   input  wire logic        uart1_sync_data,
   input  wire logic        uart1_sdt_en,
   input  wire logic        pwm2_output_b,
   input  wire logic        pwm2b_en,
   output logic             capture_compare_3_capture_in,
   output logic             uart1_sck_in,
   output logic             uart1_receive,
   output logic             uart1_sdt_in,
   output logic             analog_channel_17,
   output logic             analog_channel_18,
   output logic             analog_channel_19,
   output logic             pwm2b_pin_map_sel,
   output logic             timer3_clock_pin_map_sel,
   output logic             capture_unit3_pin_map_sel,
   output logic             capture_unit2_pin_map_sel
);

   // Picks the pin drive: peripheral value when enabled, else latch.
   function automatic logic pin_val(input logic en, input logic pv,
                                    input logic lat);
      pin_val = en ? pv : lat;
   endfunction : pin_val

   // Software-visible state.
   logic [7:0] c_lat_ff;
   logic [7:0] c_dir_ff;
   logic [7:0] c_ans_ff;
   logic [7:0] d_lat_ff;
   logic [7:0] d_dir_ff;
   logic [7:0] d_ans_ff;
   logic [7:0] slew_ff;
   logic [7:0] map_ff;
   logic [7:0] rdata_ff;
   // Two-stage pin synchronisers; stage one feeds stage two only.
   logic [7:0] c_s1_ff;
   logic [7:0] c_s2_ff;
   logic [7:0] d_s1_ff;
   logic [7:0] d_s2_ff;
   // Registered pad and peripheral outputs.
   logic [7:0] c_out_ff;
   logic [7:0] c_oe_ff;
   logic [7:0] d_out_ff;
   logic [7:0] d_oe_ff;
   logic       cap3_ff;
   logic       sck_ff;
   logic       rx_ff;
   logic       sdt_ff;
   logic       analog_channel_17_ff;
   logic       analog_channel_18_ff;
   logic       analog_channel_19_ff;

   // Address decode for write strobes.
   // The port data address and the latch address both land in the
   // latch; a read-modify-write through the latch address never copies pins,
   // but one through the port data address reads the pins and copies them.
   wire wr_c_lat = reg_wr & ((reg_addr == A_C_LAT) |
                             (reg_addr == A_C_PORT));
   wire wr_d_lat = reg_wr & ((reg_addr == A_D_LAT) |
                             (reg_addr == A_D_PORT));
   wire wr_c_dir = reg_wr & (reg_addr == A_C_DIR);
   wire wr_d_dir = reg_wr & (reg_addr == A_D_DIR);
   wire wr_c_ans = reg_wr & (reg_addr == A_C_ANS);
   wire wr_d_ans = reg_wr & (reg_addr == A_D_ANS);
   wire wr_slew  = reg_wr & (reg_addr == A_SLEW);
   wire wr_map   = reg_wr & (reg_addr == A_MAP);

   // Digital input path, blanked on analog pins so reads show zero.
   wire [7:0] c_din = c_s2_ff & ~c_ans_ff;
   wire [7:0] d_din = d_s2_ff & ~d_ans_ff;

   // Read mux; unmapped addresses and unused bits return zero.
   // Masking again on read keeps unused bits at zero even if a later
   // change lets a write reach them.
   // The latch address returns the latch, never the pin level.
   logic [7:0] nxt_rdata;
   always_comb begin
      unique case (reg_addr)
         A_C_PORT: nxt_rdata = c_din;
         A_C_LAT:  nxt_rdata = c_lat_ff;
         A_C_DIR:  nxt_rdata = c_dir_ff;
         A_C_ANS:  nxt_rdata = c_ans_ff & C_ANS_MASK;
         A_D_PORT: nxt_rdata = d_din;
         A_D_LAT:  nxt_rdata = d_lat_ff;
         A_D_DIR:  nxt_rdata = d_dir_ff;
         A_D_ANS:  nxt_rdata = d_ans_ff;
         A_SLEW:   nxt_rdata = slew_ff & SLEW_MASK;
         A_MAP:    nxt_rdata = map_ff & MAP_MASK;
         default:  nxt_rdata = ZERO8;
      endcase
   end

   // Mapping selections; capture 3 and PWM2 B use these pins
   // only in the placement that the mapping bit picks.
   wire map_capture_compare_3  = map_ff[MAP_CAPTURE_COMPARE_3];
   wire map_pwm2b = map_ff[MAP_PWM2B];

   // Peripheral output requests per pin, ordered by priority.
   // Priority only picks the value; the output enable stays with the
   // direction bit, so a peripheral cannot turn an input into a driver.
   // Analog select is left out here on purpose, as outputs win over it.
   logic [7:0] c_pen, c_pv, d_pen, d_pv;
   wire cap3_here = ~map_capture_compare_3;  // Bit 6 is the alternate placement.
   wire p6_hi = (pwm3a_en | capture_compare_3_out_en) & cap3_here;
   wire p6_lo = uart1_tx_en | uart1_sck_en;
   wire p7_lo = uart1_sdt_en;

   always_comb begin
      c_pen = ZERO8;
      c_pv  = ZERO8;
      d_pen = ZERO8;
      d_pv  = ZERO8;
      c_pen[P5] = spi1_out_en;
      c_pv[P5]  = spi1_data_out;
      c_pen[P6] = p6_hi | p6_lo;
      if (p6_hi) begin
         c_pv[P6] = pwm3a_en ? pwm3_output_a
                             : capture_compare_3;
      end else begin
         c_pv[P6] = uart1_tx_en ? uart1_transmit
                                : uart1_sync_clock;
      end
      c_pen[P7] = pwm3b_en | p7_lo;
      c_pv[P7]  = pwm3b_en ? pwm3_output_b
                           : uart1_sync_data;
      d_pen[D_PWM2B] = pwm2b_en & map_pwm2b;
      d_pv[D_PWM2B]  = pwm2_output_b;
   end

   // Per-pin drivers. The enable depends on direction only, so
   // analog select never stops the latch or a peripheral driving.
   logic [7:0] nxt_c_out, nxt_c_oe, nxt_d_out, nxt_d_oe;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         assign nxt_c_oe[g]  = ~c_dir_ff[g];
         assign nxt_d_oe[g]  = ~d_dir_ff[g];
         assign nxt_c_out[g] = pin_val(c_pen[g], c_pv[g],
                                       c_lat_ff[g]);
         assign nxt_d_out[g] = pin_val(d_pen[g], d_pv[g],
                                       d_lat_ff[g]);
      end
   endgenerate

   // Peripheral inputs, taken only when the pin is an input.
   wire nxt_cap3 = c_din[P6] & c_dir_ff[P6] & cap3_here;
   wire nxt_sck  = c_din[P6] & c_dir_ff[P6];
   wire nxt_rx   = c_din[P7] & c_dir_ff[P7];
   wire nxt_sdt  = c_din[P7] & c_dir_ff[P7];
   // Analog channel enables for the ADC mux.
   // Channel 17 has no direction term, channels 18 and 19 need input.
   wire nxt_analog_channel_17 = c_ans_ff[P5];
   wire nxt_analog_channel_18 = c_ans_ff[P6] & c_dir_ff[P6];
   wire nxt_analog_channel_19 = c_ans_ff[P7] & c_dir_ff[P7];

   // Third-port control; pins wake up as inputs so nothing drives early.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c_lat_ff <= RST_LAT;
         c_dir_ff <= RST_DIR;
         c_ans_ff <= RST_C_ANS;
      end else begin
         if (wr_c_lat) c_lat_ff <= reg_wdata;
         if (wr_c_dir) c_dir_ff <= reg_wdata;
         if (wr_c_ans) c_ans_ff <= reg_wdata & C_ANS_MASK;
      end
   end

   // Fourth-port control; the port wakes up as all analog inputs.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         d_lat_ff <= RST_LAT;
         d_dir_ff <= RST_DIR;
         d_ans_ff <= RST_D_ANS;
      end else begin
         if (wr_d_lat) d_lat_ff <= reg_wdata;
         if (wr_d_dir) d_dir_ff <= reg_wdata;
         if (wr_d_ans) d_ans_ff <= reg_wdata;
      end
   end

   // Slew control, only the implemented bits are kept.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         slew_ff <= RST_SLEW;
      end else if (wr_slew) begin
         slew_ff <= reg_wdata & SLEW_MASK;
      end
   end

   // Pin mapping bits, only the implemented bits are kept.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         map_ff <= RST_MAP;
      end else if (wr_map) begin
         map_ff <= reg_wdata & MAP_MASK;
      end
   end

   // Pin synchronisers. The pads are taken as synchronous, but two
   // stages keep a slow edge from reaching several readers apart.
   // The cost is two cycles of latency on every digital input.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c_s1_ff <= ZERO8;
         c_s2_ff <= ZERO8;
         d_s1_ff <= ZERO8;
         d_s2_ff <= ZERO8;
      end else begin
         c_s1_ff <= third_port_in;
         c_s2_ff <= c_s1_ff;
         d_s1_ff <= fourth_port_in;
         d_s2_ff <= d_s1_ff;
      end
   end

   // Read data holds only one cycle and is zero otherwise.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_ff <= ZERO8;
      end else begin
         rdata_ff <= reg_rd ? nxt_rdata : ZERO8;
      end
   end

   // Third-port pad drive; reset leaves every driver off.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c_out_ff <= ZERO8;
         c_oe_ff  <= ZERO8;
      end else begin
         c_out_ff <= nxt_c_out;
         c_oe_ff  <= nxt_c_oe;
      end
   end

   // Fourth-port pad drive; reset leaves every driver off.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         d_out_ff <= ZERO8;
         d_oe_ff  <= ZERO8;
      end else begin
         d_out_ff <= nxt_d_out;
         d_oe_ff  <= nxt_d_oe;
      end
   end

   // Registered peripheral inputs.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cap3_ff <= 1'b0;
         sck_ff  <= 1'b0;
         rx_ff   <= 1'b0;
         sdt_ff  <= 1'b0;
      end else begin
         cap3_ff <= nxt_cap3;
         sck_ff  <= nxt_sck;
         rx_ff   <= nxt_rx;
         sdt_ff  <= nxt_sdt;
      end
   end

   // Registered analog channel enables.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         analog_channel_17_ff <= 1'b0;
         analog_channel_18_ff <= 1'b0;
         analog_channel_19_ff <= 1'b0;
      end else begin
         analog_channel_17_ff <= nxt_analog_channel_17;
         analog_channel_18_ff <= nxt_analog_channel_18;
         analog_channel_19_ff <= nxt_analog_channel_19;
      end
   end

   // Every output comes straight from a flip-flop, so the pads and
   // the peripherals never see a glitch from the decode logic.
   // The price is a second cycle from a register write to the pin.
   assign reg_rdata          = rdata_ff;
   assign third_port_out     = c_out_ff;
   assign third_port_oe      = c_oe_ff;
   assign fourth_port_out    = d_out_ff;
   assign fourth_port_oe     = d_oe_ff;
   assign slew_rate_control  = slew_ff;
   assign capture_compare_3_capture_in    = cap3_ff;
   assign uart1_sck_in       = sck_ff;
   assign uart1_receive      = rx_ff;
   assign uart1_sdt_in       = sdt_ff;
   assign analog_channel_17  = analog_channel_17_ff;
   assign analog_channel_18  = analog_channel_18_ff;
   assign analog_channel_19  = analog_channel_19_ff;
   // Mapping bits go straight to the other pin groups.
   assign pwm2b_pin_map_sel         = map_ff[MAP_PWM2B];
   assign timer3_clock_pin_map_sel  = map_ff[MAP_T3CK];
   assign capture_unit3_pin_map_sel = map_ff[MAP_CAPTURE_COMPARE_3];
   assign capture_unit2_pin_map_sel = map_ff[MAP_CAPTURE_COMPARE_2];

endmodule : bpm_port_mux
`default_nettype wire

// ===== bpm_port_mux_asserts.sv
/* Checker for the port mux: register bus and pin relations.
   Bound to bpm_port_mux; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module bpm_port_mux_asserts
   import bpm_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] third_port_out,
   input wire logic [7:0] third_port_oe,
   input wire logic       spi1_data_out,
   input wire logic       spi1_out_en,
   input wire logic       pwm3_output_b,
   input wire logic       pwm3b_en,
   input wire logic       uart1_receive,
   input wire logic       analog_channel_17
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Lag checks need a quiet cycle after the write, or a second write would overtake the first.
   wire logic wr_dir = reg_wr && reg_addr == A_C_DIR;
   wire logic wr_ans = reg_wr && reg_addr == A_C_ANS;

   oe_tracks_dir_a: assert property (wr_dir ##1 !wr_dir |=> third_port_oe == ~$past(reg_wdata, 2))
      else $error("output enable does not follow direction write");
   dir_read_oe_a: assert property (reg_rd && reg_addr == A_C_DIR |=> reg_rdata == ~third_port_oe)
      else $error("direction read disagrees with output enables");
   latch_readback_a: assert property ((reg_wr && reg_addr == A_C_LAT) ##1 (reg_rd && reg_addr == A_C_LAT)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("latch read does not return written value");
   unmapped_zero_a: assert property (reg_rd && reg_addr > A_MAP |=> reg_rdata == ZERO8)
      else $error("unmapped read not zero");
   ans_low_zero_a: assert property (reg_rd && reg_addr == A_C_ANS |=> reg_rdata[1:0] == 2'h0)
      else $error("unimplemented analog select bits not zero");
   spi_drives_pin_a: assert property (spi1_out_en |=> third_port_out[P5] == $past(spi1_data_out))
      else $error("bit 5 does not carry serial data out");
   pwm3b_wins_a: assert property (pwm3b_en |=> third_port_out[P7] == $past(pwm3_output_b))
      else $error("bit 7 does not carry pwm output b");
   rx_needs_input_a: assert property (uart1_receive |-> !third_port_oe[P7])
      else $error("receive input active while pin drives");
   analog_channel_17_follows_a: assert property (wr_ans ##1 !wr_ans |=> analog_channel_17 == |($past(reg_wdata, 2) & 8'h20))
      else $error("analog channel 17 does not follow select");

   // Main scenarios reached.
   dir_write_c: cover property (wr_dir ##1 !wr_dir);
   spi_hold_c: cover property (spi1_out_en ##1 spi1_out_en);
   unmapped_c: cover property (reg_rd && reg_addr > A_MAP);
endmodule : bpm_port_mux_asserts

bind bpm_port_mux bpm_port_mux_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .third_port_out(third_port_out), .third_port_oe(third_port_oe), .spi1_data_out(spi1_data_out),
   .spi1_out_en(spi1_out_en), .pwm3_output_b(pwm3_output_b), .pwm3b_en(pwm3b_en),
   .uart1_receive(uart1_receive), .analog_channel_17(analog_channel_17));
`default_nettype wire

// ===== bpm_pad_model.sv
/* External circuitry on one 8-bit port.
   Assumes the bench sets the outside levels; no pulls on the wires. */
`timescale 1ns/1ps
`default_nettype none
module bpm_pad_model (
   input  wire logic [7:0] oe,
   input  wire logic [7:0] dout,
   input  wire logic [7:0] ext,
   output logic      [7:0] level
);
   // A driven pin shows the device's value, a released one the outside level.
   assign level = (oe & dout) | (~oe & ext);
endmodule : bpm_pad_model
`default_nettype wire

// ===== bidir_port_pin_mux_tb.sv
/* Self-checking bench for the port mux with a register model.
   Assumes a 25 MHz clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module bidir_port_pin_mux_tb import bpm_pkg::*;;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic [15:0] pv = 16'h0000;
   logic [7:0]  tx = 8'h00;
   logic [7:0]  fx = 8'h00;
   logic [7:0]  rdata, tpi, tpo, toe, fpi, fpo, foe, slew, g;
   logic [3:0]  pin_o, msel, a;
   logic [2:0]  an;
   logic [7:0]  m [10];
   logic [7:0]  mk [10] = '{8'hff, 8'hff, 8'hff, C_ANS_MASK, 8'hff, 8'hff, 8'hff, 8'hff, SLEW_MASK, MAP_MASK};
   int          failures = 0;
   int          checked = 0;

   // Clock of 40 ns period.
   always #20 sys_clk = ~sys_clk;

   // Peripheral pairs come from pv: even bit value, odd bit enable.
   bpm_port_mux DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata(rdata), .third_port_in(tpi), .third_port_out(tpo), .third_port_oe(toe),
      .fourth_port_in(fpi), .fourth_port_out(fpo), .fourth_port_oe(foe), .slew_rate_control(slew),
      .spi1_data_out(pv[0]), .spi1_out_en(pv[1]), .capture_compare_3(pv[2]), .capture_compare_3_out_en(pv[3]),
      .pwm3_output_a(pv[4]), .pwm3a_en(pv[5]), .pwm3_output_b(pv[6]), .pwm3b_en(pv[7]),
      .uart1_transmit(pv[8]), .uart1_tx_en(pv[9]), .uart1_sync_clock(pv[10]), .uart1_sck_en(pv[11]),
      .uart1_sync_data(pv[12]), .uart1_sdt_en(pv[13]), .pwm2_output_b(pv[14]), .pwm2b_en(pv[15]),
      .capture_compare_3_capture_in(pin_o[3]), .uart1_sck_in(pin_o[2]), .uart1_receive(pin_o[1]), .uart1_sdt_in(pin_o[0]),
      .analog_channel_17(an[0]), .analog_channel_18(an[1]), .analog_channel_19(an[2]),
      .pwm2b_pin_map_sel(msel[3]), .timer3_clock_pin_map_sel(msel[2]),
      .capture_unit3_pin_map_sel(msel[1]), .capture_unit2_pin_map_sel(msel[0]));
   bpm_pad_model u_tpad (.oe(toe), .dout(tpo), .ext(tx), .level(tpi));
   bpm_pad_model u_fpad (.oe(foe), .dout(fpo), .ext(fx), .level(fpi));

   // Comparison and verdict.
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Model read value; port data assumes peripherals idle, the pin is then latch or outside level.
   function automatic logic [7:0] exp_rd(input logic [3:0] ai);
      if (ai == A_C_PORT)
         return ((~m[2] & m[1]) | (m[2] & tx)) & ~m[3];
      if (ai == A_D_PORT)
         return ((~m[6] & m[5]) | (m[6] & fx)) & ~m[7];
      return (ai <= A_MAP) ? m[ai] : ZERO8;
   endfunction : exp_rd
   // Expected drive values, highest priority first.
   function automatic logic [15:0] exp_out();
      logic [7:0] t;
      logic [7:0] f;
      t = m[1];
      f = m[5];
      if (pv[1]) t[P5] = pv[0];
      if (!m[9][MAP_CAPTURE_COMPARE_3] && (pv[5] || pv[3])) t[P6] = pv[5] ? pv[4] : pv[2];
      else if (pv[9] || pv[11]) t[P6] = pv[9] ? pv[8] : pv[10];
      if (pv[7] || pv[13]) t[P7] = pv[7] ? pv[6] : pv[12];
      if (m[9][MAP_PWM2B] && pv[15]) f[D_PWM2B] = pv[14];
      return {f, t};
   endfunction : exp_out

   // Bus tasks; the write strobe stays up until the next read or idle, so no signal is set twice per step.
   task automatic wr(input logic [3:0] ai, input logic [7:0] d);
      addr <= ai;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      if (ai == A_C_PORT || ai == A_D_PORT) m[ai + 4'h1] = d;
      else if (ai <= A_MAP) m[ai] = d & mk[ai];
   endtask : wr
   task automatic rd(input logic [3:0] ai);
      addr <= ai;
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      @(posedge sys_clk);
      chk("read data", {16'h0, rdata}, {16'h0, exp_rd(ai)});
   endtask : rd
   task automatic idle(input int n);
      wr_s <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask : idle
   task automatic pads();
      chk("enables", {toe, foe, 8'h0}, {~m[2], ~m[6], 8'h0});
      chk("drive", {8'h0, fpo, tpo}, {8'h0, exp_out()});
      chk("status", {an, msel, 9'h0, slew}, {m[3][7] & m[2][7], m[3][6] & m[2][6], m[3][5], m[9][5], m[9][4],
         m[9][2], m[9][0], 9'h0, m[8]});
   endtask : pads

   // Reset, register sweep, output priority, then input paths.
   initial begin
      a = 4'($urandom(32'h40b3));
      m = '{ZERO8, RST_LAT, RST_DIR, RST_C_ANS, ZERO8, RST_LAT, RST_DIR, RST_D_ANS, RST_SLEW, RST_MAP};
      tx = 8'($urandom);
      fx = 8'($urandom);
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      idle(4);
      pads();
      for (int i = 0; i < 16; i++) rd(4'(i));
      repeat (40) begin
         tx <= 8'($urandom);
         fx <= 8'($urandom);
         a = 4'($urandom);
         wr(a, 8'($urandom));
         if (a[1:0] == 2'h0) idle(4);
         rd(a);
      end
      idle(2);
      pads();
      wr(A_C_DIR, 8'h00);
      wr(A_D_DIR, 8'h00);
      repeat (30) begin
         pv <= 16'($urandom);
         wr(A_C_ANS, 8'($urandom));
         wr(A_MAP, 8'($urandom));
         idle(2);
         pads();
      end
      pv <= 16'h0000;
      repeat (20) begin
         tx <= 8'($urandom);
         fx <= 8'($urandom);
         wr(A_C_DIR, 8'($urandom));
         wr(A_C_ANS, 8'($urandom));
         wr(A_D_DIR, 8'($urandom));
         wr(A_D_ANS, 8'($urandom));
         wr(A_MAP, 8'($urandom));
         idle(5);
         g = tx & m[2] & ~m[3];
         chk("inputs", {20'h0, pin_o}, {20'h0, g[6] & ~m[9][2], g[6], g[7], g[7]});
         rd(A_C_PORT);
         rd(A_D_PORT);
         pads();
      end
      report_and_stop();
   end
endmodule : bidir_port_pin_mux_tb
`default_nettype wire
